// ### hdl/pplor_defines.vh
// register offsets, field positions and reset values of the port block
`ifndef PPLOR_DEFINES_VH
`define PPLOR_DEFINES_VH

`define PPLOR_OFS_PA_OUT    8'h00
`define PPLOR_OFS_PA_DIR    8'h04
`define PPLOR_OFS_PA_PIN    8'h08
`define PPLOR_OFS_PB_OUT    8'h0C
`define PPLOR_OFS_PB_DIR    8'h10
`define PPLOR_OFS_PB_PIN    8'h14
`define PPLOR_OFS_PC_OUT    8'h18
`define PPLOR_OFS_PC_DIR    8'h1C
`define PPLOR_OFS_PC_PIN    8'h20
`define PPLOR_OFS_PG_OUT    8'h24
`define PPLOR_OFS_PG_DIR    8'h28
`define PPLOR_OFS_PG_PIN    8'h2C
`define PPLOR_OFS_LCD_CTRL  8'h30
`define PPLOR_OFS_PORT_STEP 8'h0C

`define PPLOR_RST_OUT       8'h00
`define PPLOR_RST_DIR       8'h00
`define PPLOR_RST_PG        5'h00
`define PPLOR_RST_LCD_MAP   4'h0

`define PPLOR_LCD_EN_BIT    7
`define PPLOR_LCD_MAP_MSB   3
`define PPLOR_LCD_MAP_LSB   0

`define PPLOR_MAP_PG4_MIN   4'h5
`define PPLOR_MAP_PG3_MIN   4'h6
`define PPLOR_MAP_PG10_MIN  4'h0

`define PPLOR_PG_T0_BIT     4
`define PPLOR_PG_T1_BIT     3
`define PPLOR_PG_SEGMENT_LINE_4_BIT   2
`define PPLOR_PG_SEGMENT_LINE_13_BIT  1
`define PPLOR_PG_SEGMENT_LINE_14_BIT  0

`define PPLOR_RDATA_ZERO    32'h00000000

`endif

// ### hdl/pplor_port_ctrl.v
// general purpose ports a, b, c and g with lcd segment takeover of port g
// Overview of operation
// R1: port g bit 4 digital input drives counter 0 external clock.
// R2: port g bit 3 digital input drives counter 1 external clock.
// R3: lcd on and map above 5: g4 pull-up off, output, input disabled.
// R4: g4 analog path carries segment 23, taking priority over counter 0 clock.
// R5: lcd on and map above 6: g3 pull-up off, input, input disabled.
// R6: lcd on: g2 pull-up off, input, input disabled, segment 4.
// R7: lcd on and map above 0: g1, g0 pull-up off, input, input disabled.
// R8: g1 carries segment 13 and g0 segment 14 when taken over.
// R9: ports a, b, c have 8-bit read/write output-level registers, reset 0.
// R10: ports a, b, c have 8-bit read/write direction registers, reset 0.
// R11: ports a, b, c pin-input registers follow pins, no reset, listed read/write.
// R12: without takeover, port g pins follow ordinary port register settings.
`timescale 1ns/100ps
`include "pplor_defines.vh"

module pplor_port_ctrl #(
	parameter NUM_PORTS = 3,
	parameter PORT_W    = 8,
	parameter PG_W      = 5
) (
	input  wire                        clk_sys,
	input  wire                        arst_n,
	input  wire [7:0]                  avs_address,
	input  wire                        avs_read,
	input  wire                        avs_write,
	input  wire [31:0]                 avs_writedata,
	input  wire [3:0]                  avs_byteenable,
	output reg  [31:0]                 avs_readdata,
	output reg                         avs_waitrequest,
	input  wire [NUM_PORTS*PORT_W-1:0] port_abc_in,
	output reg  [NUM_PORTS*PORT_W-1:0] port_abc_out_q,
	output reg  [NUM_PORTS*PORT_W-1:0] port_abc_oe_n_q,
	output reg  [NUM_PORTS*PORT_W-1:0] port_abc_pullup_q,
	input  wire [PG_W-1:0]             port_g_in,
	output reg  [PG_W-1:0]             port_g_out_q,
	output reg  [PG_W-1:0]             port_g_oe_n_q,
	output reg  [PG_W-1:0]             port_g_pullup_q,
	output reg  [PG_W-1:0]             port_g_in_en_q,
	input  wire                        segment_line_4,
	input  wire                        segment_line_13,
	input  wire                        segment_line_14,
	input  wire                        segment_line_23,
	input  wire                        segment_line_24,
	output reg  [PG_W-1:0]             port_g_seg_connect_q,
	output reg  [PG_W-1:0]             port_g_analog_q,
	output reg                         counter0_ext_clock_in,
	output reg                         counter1_ext_clock_in
);

	// software state
	reg  [PORT_W-1:0] out_lvl_q [0:NUM_PORTS-1];
	reg  [PORT_W-1:0] dir_q     [0:NUM_PORTS-1];
	reg  [PORT_W-1:0] pin_q     [0:NUM_PORTS-1];
	reg  [PG_W-1:0]   pg_out_lvl_q;
	reg  [PG_W-1:0]   pg_dir_q;
	reg  [PG_W-1:0]   pg_pin_q;
	reg               lcd_enable_bit;
	reg  [3:0]        lcd_pin_map_field;

	// bus handshake
	reg               ack_q;
	wire              req;
	wire              wr_take;
	wire [7:0]        wadr;

	assign req     = avs_read | avs_write;
	assign wr_take = avs_write & ack_q;
	assign wadr    = {avs_address[7:2], 2'b00};

	// two-cycle answer: waitrequest drops on the first edge that sees the request
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// own flop so the bus sees no logic after the register
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= ~(req & ~ack_q);
	end

	// ports a, b, c
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
			// each port owns three words, one step apart
			wire [31:0] base_full;
			wire [7:0]  base;
			wire        hit_out;
			wire        hit_dir;
			assign base_full = gi * `PPLOR_OFS_PORT_STEP;
			assign base      = base_full[7:0];
			assign hit_out   = wr_take && avs_byteenable[0] && (wadr == base + `PPLOR_OFS_PA_OUT);
			assign hit_dir   = wr_take && avs_byteenable[0] && (wadr == base + `PPLOR_OFS_PA_DIR);

			always @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n)
					out_lvl_q[gi] <= `PPLOR_RST_OUT; // R9
				else if (hit_out)
					out_lvl_q[gi] <= avs_writedata[PORT_W-1:0]; // R9
			end

			always @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n)
					dir_q[gi] <= `PPLOR_RST_DIR; // R10
				else if (hit_dir)
					dir_q[gi] <= avs_writedata[PORT_W-1:0]; // R10
			end

			// pin sample has no reset value; writes to it are accepted and dropped
			always @(posedge clk_sys) begin
				pin_q[gi] <= port_abc_in[gi*PORT_W +: PORT_W]; // R11
			end

			always @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n)
					port_abc_out_q[gi*PORT_W +: PORT_W] <= `PPLOR_RST_OUT;
				else
					port_abc_out_q[gi*PORT_W +: PORT_W] <= out_lvl_q[gi];
			end

			always @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n)
					port_abc_oe_n_q[gi*PORT_W +: PORT_W] <= {PORT_W{1'b1}};
				else
					port_abc_oe_n_q[gi*PORT_W +: PORT_W] <= ~dir_q[gi];
			end

			// pull-up only on an input whose level bit is set
			always @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n)
					port_abc_pullup_q[gi*PORT_W +: PORT_W] <= {PORT_W{1'b0}};
				else
					port_abc_pullup_q[gi*PORT_W +: PORT_W] <= out_lvl_q[gi] & ~dir_q[gi];
			end
		end
	endgenerate

	// port g and lcd control registers
	wire pg_out_hit;
	wire pg_dir_hit;
	wire lcd_ctrl_hit;

	// write strobes, one per writable register word; the port g pin word has none
	assign pg_out_hit   = wr_take && avs_byteenable[0] && (wadr == `PPLOR_OFS_PG_OUT);
	assign pg_dir_hit   = wr_take && avs_byteenable[0] && (wadr == `PPLOR_OFS_PG_DIR);
	assign lcd_ctrl_hit = wr_take && avs_byteenable[0] && (wadr == `PPLOR_OFS_LCD_CTRL);

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			pg_out_lvl_q <= `PPLOR_RST_PG;
		else if (pg_out_hit)
			pg_out_lvl_q <= avs_writedata[PG_W-1:0];
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			pg_dir_q <= `PPLOR_RST_PG;
		else if (pg_dir_hit)
			pg_dir_q <= avs_writedata[PG_W-1:0];
	end

	// enable and pin map share one word, so they change together
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lcd_enable_bit    <= 1'b0;
			lcd_pin_map_field <= `PPLOR_RST_LCD_MAP;
		end else if (lcd_ctrl_hit) begin
			lcd_enable_bit    <= avs_writedata[`PPLOR_LCD_EN_BIT];
			lcd_pin_map_field <= avs_writedata[`PPLOR_LCD_MAP_MSB:`PPLOR_LCD_MAP_LSB];
		end
	end

	// raw pin sample; the read path applies the input enable
	always @(posedge clk_sys) begin
		pg_pin_q <= port_g_in;
	end

	// lcd takeover terms, one per port g pin
	wire [PG_W-1:0] pullup_override_enable;
	wire [PG_W-1:0] direction_override_enable;
	wire [PG_W-1:0] direction_override_value;
	wire [PG_W-1:0] input_enable_override_enable;
	wire [PG_W-1:0] pullup_override_value;
	wire [PG_W-1:0] input_enable_override_value;
	wire [PG_W-1:0] output_value_override_enable;
	wire [PG_W-1:0] lcd_take;

	assign lcd_take[4] = lcd_enable_bit & (lcd_pin_map_field > `PPLOR_MAP_PG4_MIN);  // R3
	assign lcd_take[3] = lcd_enable_bit & (lcd_pin_map_field > `PPLOR_MAP_PG3_MIN);  // R5
	assign lcd_take[2] = lcd_enable_bit;                                             // R6
	assign lcd_take[1] = lcd_enable_bit & (lcd_pin_map_field > `PPLOR_MAP_PG10_MIN); // R7
	assign lcd_take[0] = lcd_take[1];                                                // R7

	assign pullup_override_enable       = lcd_take;
	assign pullup_override_value        = {PG_W{1'b0}};
	assign direction_override_enable    = lcd_take;
	// only the segment 23 pin is forced to output
	assign direction_override_value     = 5'h10; // R3
	assign output_value_override_enable = {PG_W{1'b0}};
	assign input_enable_override_enable = lcd_take;
	assign input_enable_override_value  = {PG_W{1'b0}};

	reg [PG_W-1:0] pg_dir_d;
	reg [PG_W-1:0] pg_pu_d;
	reg [PG_W-1:0] pg_ie_d;
	reg [PG_W-1:0] pg_seg_lvl;
	integer        k;

	always @* begin
		pg_dir_d   = pg_dir_q;
		pg_pu_d    = pg_out_lvl_q & ~pg_dir_q;
		pg_ie_d    = {PG_W{1'b1}};
		pg_seg_lvl = {segment_line_23, segment_line_24, segment_line_4,
			segment_line_13, segment_line_14}; // R4 R8
		for (k = 0; k < PG_W; k = k + 1) begin
			if (pullup_override_enable[k])
				pg_pu_d[k] = pullup_override_value[k]; // R3 R5 R6 R7
			if (direction_override_enable[k])
				pg_dir_d[k] = direction_override_value[k]; // R3 R5 R6 R7
			if (input_enable_override_enable[k])
				pg_ie_d[k] = input_enable_override_value[k]; // R3 R5 R6 R7
		end
	end

	// level overrides never touch the port value
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			port_g_out_q <= `PPLOR_RST_PG;
		else
			port_g_out_q <= pg_out_lvl_q & ~output_value_override_enable; // R12
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			port_g_oe_n_q <= {PG_W{1'b1}};
		else
			port_g_oe_n_q <= ~pg_dir_d; // R12
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			port_g_pullup_q <= `PPLOR_RST_PG;
		else
			port_g_pullup_q <= pg_pu_d; // R12
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			port_g_in_en_q <= {PG_W{1'b1}};
		else
			port_g_in_en_q <= pg_ie_d; // R12
	end

	// analog path closes only while the pin is taken over
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			port_g_seg_connect_q <= `PPLOR_RST_PG;
		else
			port_g_seg_connect_q <= lcd_take; // R4 R8
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			port_g_analog_q <= `PPLOR_RST_PG;
		else
			port_g_analog_q <= lcd_take & pg_seg_lvl; // R4 R8
	end

	// disabled input reads low, so segment use starves the counters
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			counter0_ext_clock_in <= 1'b0;
		else
			counter0_ext_clock_in <= port_g_in[`PPLOR_PG_T0_BIT] & pg_ie_d[`PPLOR_PG_T0_BIT]; // R1 R4
	end

	// counter 1 loses its clock the same way once segment 24 is on
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			counter1_ext_clock_in <= 1'b0;
		else
			counter1_ext_clock_in <= port_g_in[`PPLOR_PG_T1_BIT] & pg_ie_d[`PPLOR_PG_T1_BIT]; // R2
	end

	// read mux, loaded on the same edge that waitrequest falls
	reg [31:0] rdata_d;
	always @* begin
		rdata_d = `PPLOR_RDATA_ZERO;
		case (wadr)
			`PPLOR_OFS_PA_OUT:   rdata_d[PORT_W-1:0] = out_lvl_q[0];
			`PPLOR_OFS_PA_DIR:   rdata_d[PORT_W-1:0] = dir_q[0];
			`PPLOR_OFS_PA_PIN:   rdata_d[PORT_W-1:0] = pin_q[0]; // R11
			`PPLOR_OFS_PB_OUT:   rdata_d[PORT_W-1:0] = out_lvl_q[1];
			`PPLOR_OFS_PB_DIR:   rdata_d[PORT_W-1:0] = dir_q[1];
			`PPLOR_OFS_PB_PIN:   rdata_d[PORT_W-1:0] = pin_q[1]; // R11
			`PPLOR_OFS_PC_OUT:   rdata_d[PORT_W-1:0] = out_lvl_q[2];
			`PPLOR_OFS_PC_DIR:   rdata_d[PORT_W-1:0] = dir_q[2];
			`PPLOR_OFS_PC_PIN:   rdata_d[PORT_W-1:0] = pin_q[2]; // R11
			`PPLOR_OFS_PG_OUT:   rdata_d[PG_W-1:0]   = pg_out_lvl_q;
			`PPLOR_OFS_PG_DIR:   rdata_d[PG_W-1:0]   = pg_dir_q;
			`PPLOR_OFS_PG_PIN:   rdata_d[PG_W-1:0]   = pg_pin_q & pg_ie_d;
			`PPLOR_OFS_LCD_CTRL: begin
				rdata_d[`PPLOR_LCD_EN_BIT] = lcd_enable_bit;
				rdata_d[`PPLOR_LCD_MAP_MSB:`PPLOR_LCD_MAP_LSB] = lcd_pin_map_field;
			end
			default:             rdata_d = `PPLOR_RDATA_ZERO;
		endcase
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= `PPLOR_RDATA_ZERO;
		end else if (avs_read && !ack_q) begin
			// loaded once per read, held until the next one
			avs_readdata <= rdata_d;
		end
	end

endmodule

// ### tb/pplor_sva.sv
// assertions on the port block pins and bus answer
`timescale 1ns/100ps
module pplor_sva (
	input wire        clk_sys,
	input wire        arst_n,
	input wire        avs_read,
	input wire        avs_write,
	input wire        avs_waitrequest,
	input wire [23:0] port_abc_out_q,
	input wire [23:0] port_abc_oe_n_q,
	input wire [23:0] port_abc_pullup_q,
	input wire [4:0]  port_g_in,
	input wire [4:0]  port_g_out_q,
	input wire [4:0]  port_g_oe_n_q,
	input wire [4:0]  port_g_pullup_q,
	input wire [4:0]  port_g_in_en_q,
	input wire        segment_line_4,
	input wire        segment_line_13,
	input wire        segment_line_14,
	input wire        segment_line_23,
	input wire        segment_line_24,
	input wire [4:0]  port_g_seg_connect_q,
	input wire [4:0]  port_g_analog_q,
	input wire        counter0_ext_clock_in,
	input wire        counter1_ext_clock_in
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	wire [4:0] sg = {segment_line_23, segment_line_24, segment_line_4, segment_line_13, segment_line_14};
	wire [4:0] cn = port_g_seg_connect_q;
	wire       rq = avs_read | avs_write;
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	a_wait_answer: assert property (rq && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
		else $error("request not answered");
	a_abc_pullup: assert property (port_abc_pullup_q == (port_abc_out_q & port_abc_oe_n_q))
		else $error("port pull-up mismatch");
	a_g_plain: assert property (((port_g_pullup_q ^ (port_g_out_q & port_g_oe_n_q)) & ~cn) == 5'h00)
		else $error("port g plain pull-up mismatch");
	a_g_takeover: assert property (port_g_in_en_q == ~cn && (port_g_pullup_q & cn) == 5'h00
		&& !(cn[4] && port_g_oe_n_q[4]) && (cn[3:0] & ~port_g_oe_n_q[3:0]) == 4'h0) else $error("takeover");
	a_map_nest: assert property (cn[3] <= cn[4] && cn[4] <= cn[1] && cn[1] == cn[0] && cn[1] <= cn[2])
		else $error("map threshold order");
	a_seg_path: assert property ($past(arst_n) && cn == $past(cn) |-> port_g_analog_q == ($past(sg) & cn))
		else $error("segment path");
	a_count_clk: assert property ($past(arst_n) && $stable(port_g_in_en_q[4:3]) |->
		{counter0_ext_clock_in, counter1_ext_clock_in} == ($past(port_g_in[4:3]) & port_g_in_en_q[4:3]))
		else $error("counter clock input");
	c_full: cover property (&cn);
	c_part: cover property (cn == 5'h07);
	c_answer: cover property (rq && !avs_waitrequest);
endmodule
bind pplor_port_ctrl pplor_sva u_sva (.*);

// ### tb/pplor_pins.sv
// pin model: driven pins show their level, released ones the far side
`timescale 1ns/100ps
module pplor_pins (
	input  wire [23:0] abc_out,
	input  wire [23:0] abc_oe_n,
	input  wire [4:0]  g_out,
	input  wire [4:0]  g_oe_n,
	input  wire [23:0] abc_ext,
	input  wire [4:0]  g_ext,
	output wire [23:0] abc_pin,
	output wire [4:0]  g_pin
);
	assign abc_pin = (~abc_oe_n & abc_out) | (abc_oe_n & abc_ext);
	assign g_pin   = (~g_oe_n & g_out) | (g_oe_n & g_ext);
endmodule

// ### tb/tb_top.sv
// bench of the port block: bus access, pins, lcd takeover sweep
`timescale 1ns/100ps
module tb_top;
	reg         clk_sys = 1'b0;
	reg         arst_n = 1'b0;
	reg  [7:0]  adr = 8'h00;
	reg         rd = 1'b0;
	reg         wr = 1'b0;
	reg  [31:0] wd = 32'h0;
	reg  [23:0] abc_ext = 24'h0;
	reg  [4:0]  g_ext = 5'h00;
	reg  [4:0]  sg = 5'h00;
	reg  [31:0] rs = 32'h2F;
	reg  [31:0] v;
	reg  [4:0]  cn;
	wire [31:0] rdat;
	wire        wt, c0, c1;
	wire [23:0] abc_in, abc_out, abc_oe_n;
	wire [4:0]  g_in, g_out, g_oe_n, g_cn, g_an;
	integer     miscompares = 0;
	integer     n_tests = 0;
	integer     i, p;
	always #50 clk_sys = ~clk_sys;
	pplor_port_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
		.avs_waitrequest(wt), .port_abc_in(abc_in), .port_abc_out_q(abc_out),
		.port_abc_oe_n_q(abc_oe_n), .port_abc_pullup_q(), .port_g_in(g_in), .port_g_out_q(g_out),
		.port_g_oe_n_q(g_oe_n), .port_g_pullup_q(), .port_g_in_en_q(),
		.segment_line_4(sg[2]), .segment_line_13(sg[1]), .segment_line_14(sg[0]),
		.segment_line_23(sg[4]), .segment_line_24(sg[3]), .port_g_seg_connect_q(g_cn),
		.port_g_analog_q(g_an), .counter0_ext_clock_in(c0), .counter1_ext_clock_in(c1));
	pplor_pins far (.abc_out(abc_out), .abc_oe_n(abc_oe_n), .g_out(g_out), .g_oe_n(g_oe_n),
		.abc_ext(abc_ext), .g_ext(g_ext), .abc_pin(abc_in), .g_pin(g_in));
	function [31:0] rnd(input [31:0] x);
		reg [31:0] y;
		begin
			y = x ^ (x << 13);
			y = y ^ (y >> 17);
			rnd = y ^ (y << 5);
		end
	endfunction
	function [4:0] conn(input en, input [3:0] m);
		conn = en ? {m > 4'h5, m > 4'h6, 1'b1, m > 4'h0, m > 4'h0} : 5'h00;
	endfunction
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// gap edge first, so no request line is assigned twice in a step
	task bus(input w, input [7:0] a, input [31:0] dat);
		integer k;
		begin
			@(posedge clk_sys);
			adr <= a;
			wr <= w;
			rd <= ~w;
			wd <= dat;
			k = 0;
			do begin
				@(posedge clk_sys);
				k = k + 1;
			end while (wt !== 1'b0 && k < 20);
			v = rdat;
			rd <= 1'b0;
			wr <= 1'b0;
			if (k >= 20) begin
				miscompares = miscompares + 1;
				results;
			end
		end
	endtask
	task results;
		begin
			$display("tests %0d miscompares %0d", n_tests, miscompares);
			if (miscompares == 0 && n_tests > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		miscompares = miscompares + 1;
		results;
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		for (i = 0; i < 6; i = i + 1) begin
			bus(1'b0, 8'(i * 4 + i / 2 * 4), 32'h0);
			chk("reset", 32'h0, v);
		end
		bus(1'b1, 8'h40, 32'hFF);
		bus(1'b0, 8'h40, 32'h0);
		chk("unmap", 32'h0, v);
		for (i = 0; i < 24; i = i + 1) begin
			rs = rnd(rs);
			p = rs % 3;
			abc_ext <= {rs[7:0], rs[31:16]};
			bus(1'b1, 8'(p * 12), {24'h0, rs[15:8]});
			bus(1'b1, 8'(p * 12 + 4), {24'h0, rs[23:16]});
			bus(1'b1, 8'(p * 12 + 8), {24'h0, ~rs[15:8]});
			bus(1'b0, 8'(p * 12), 32'h0);
			chk("out", {24'h0, rs[15:8]}, v);
			bus(1'b0, 8'(p * 12 + 4), 32'h0);
			chk("dir", {24'h0, rs[23:16]}, v);
			bus(1'b0, 8'(p * 12 + 8), 32'h0);
			chk("pin", {24'h0, (rs[23:16] & rs[15:8]) | (~rs[23:16] & abc_ext[p*8 +: 8])}, v);
		end
		for (i = 0; i < 32; i = i + 1) begin
			rs = rnd(rs);
			g_ext <= rs[20:16];
			sg <= rs[25:21];
			cn = conn(i[4], i[3:0]);
			bus(1'b1, 8'h24, {27'h0, rs[4:0]});
			bus(1'b1, 8'h28, {27'h0, rs[12:8]});
			bus(1'b1, 8'h30, {24'h0, i[4], 3'h0, i[3:0]});
			// outputs lag one edge, counter clocks one more via the pins
			repeat (3) @(posedge clk_sys);
			chk("connect", {27'h0, cn}, {27'h0, g_cn});
			chk("oe_n", {27'h0, (~rs[12:8] & ~cn) | (cn & 5'h0F)}, {27'h0, g_oe_n});
			chk("count0", {31'h0, ~cn[4] & (rs[12] ? rs[4] : g_ext[4])}, {31'h0, c0});
			chk("count1", {31'h0, ~cn[3] & (rs[11] ? rs[3] : g_ext[3])}, {31'h0, c1});
			chk("segment", {27'h0, cn & sg}, {27'h0, g_an});
			bus(1'b0, 8'h30, 32'h0);
			chk("lcd", {24'h0, i[4], 3'h0, i[3:0]}, v);
		end
		results;
	end
endmodule
